// [hdl/rail_seq_pkg.sv]
// Constants for the power-up rail sequencer
package rail_seq_pkg;
   // ****************************************
   // Clock and timing
   // ****************************************
   localparam int CLK_HZ = 25000000;
   localparam int EN_DLY_MS = 11;
   localparam int MON_MS = 10;
   localparam int RST_DLY_MS = 10;
   localparam int GLITCH_MIN_US = 20;
   localparam int GLITCH_MAX_US = 1000;
   // Cycle counts derived from the clock rate
   localparam int EN_DLY_CYC = EN_DLY_MS * (CLK_HZ / 1000);
   localparam int MON_CYC = MON_MS * (CLK_HZ / 1000);
   localparam int RST_DLY_CYC = RST_DLY_MS * (CLK_HZ / 1000);
   // Filter window: longest dip ignored, rounded down, inside the allowed span
   localparam int GLITCH_CYC = GLITCH_MIN_US * (CLK_HZ / 1000000);
   localparam int CNT_W = 24;
   localparam int FLT_W = 16;
   // ****************************************
   // Sequencer states
   // ****************************************
   typedef enum logic [2:0]
   {
      ST_OFF = 3'h0,
      ST_EN_WAIT = 3'h1,
      ST_CORE = 3'h2,
      ST_MID = 3'h3,
      ST_IO = 3'h4,
      ST_RST_WAIT = 3'h5,
      ST_ON = 3'h6,
      ST_FAULT = 3'h7
   } seq_state_t;
endpackage : rail_seq_pkg

// [hdl/power_up_rail_sequencer.sv]
// Power-up rail sequencer with supply monitor glitch filters
`timescale 1ns/1ps
module power_up_rail_sequencer
#(
   // Sequencer clock rate; a bench may lower it to shorten every wait
   parameter int CLK_HZ = rail_seq_pkg::CLK_HZ
)
(
   // Clock and reset
   input wire logic core_clk,
   input wire logic rst_n,
   // Host request
   input wire logic system_on_request,
   // Supply monitors, high when rail above threshold
   input wire logic core_rail_good,
   input wire logic mid_rail_good,
   input wire logic io_rail_good,
   // Rail enables, system reset and fault flag
   output logic core_rail_enable,
   output logic mid_rail_enable,
   output logic io_rail_enable,
   output logic system_reset_n,
   output logic seq_fault
);
   // Cycle counts follow the clock rate, so the millisecond figures hold at any rate that is a whole number of kHz
   localparam int EN_CYC = rail_seq_pkg::EN_DLY_MS * (CLK_HZ / 1000);
   localparam int MON_CYC = rail_seq_pkg::MON_MS * (CLK_HZ / 1000);
   localparam int RST_CYC = rail_seq_pkg::RST_DLY_MS * (CLK_HZ / 1000);
   localparam int GLITCH_CYC = rail_seq_pkg::GLITCH_MIN_US * (CLK_HZ / 1000000);
   // ****************************************
   // Input synchronisers
   // ****************************************
   logic [2:0] req_sync_ff;
   logic req_ff;
   logic req_rise;
   logic [2:0] good_raw;
   logic [2:0] good_flt;
   assign good_raw = {io_rail_good, mid_rail_good, core_rail_good};

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         req_sync_ff <= 3'h0;
         req_ff <= 1'b0;
      end
      else
      begin
         req_sync_ff <= {req_sync_ff[1:0], system_on_request};
         if (req_sync_ff[1] == req_sync_ff[2])
            req_ff <= req_sync_ff[2];
      end
   end
   assign req_rise = req_sync_ff[1] & req_sync_ff[2] & ~req_ff;

   // ****************************************
   // Supply monitor glitch filters
   // ****************************************
   // Each monitor reports a drop only after it has lasted the full window
   genvar gi;
   generate
      for (gi = 0; gi < 3; gi++)
      begin : g_flt
         logic [2:0] s_ff;
         logic good_ff;
         logic [rail_seq_pkg::FLT_W-1:0] low_cnt_ff;
         logic agree;
         assign agree = (s_ff[1] == s_ff[2]);
         always_ff @(posedge core_clk)
         begin
            if (!rst_n)
            begin
               s_ff <= 3'h0;
               good_ff <= 1'b0;
               low_cnt_ff <= '0;
            end
            else
            begin
               s_ff <= {s_ff[1:0], good_raw[gi]};
               if (agree && s_ff[2])
               begin
                  good_ff <= 1'b1;
                  low_cnt_ff <= '0;
               end
               else if (agree && !s_ff[2])
               begin
                  if (low_cnt_ff >= rail_seq_pkg::FLT_W'(GLITCH_CYC))
                     good_ff <= 1'b0;
                  else
                     low_cnt_ff <= low_cnt_ff + 1'b1;
               end
            end
         end
         assign good_flt[gi] = good_ff;
      end
   endgenerate

   // ****************************************
   // Sequencer
   // ****************************************
   // Counters run on the sequencer clock; a dropped request aborts at any point
   rail_seq_pkg::seq_state_t state_ff;
   rail_seq_pkg::seq_state_t nxt_state;
   logic [rail_seq_pkg::CNT_W-1:0] cnt_ff;
   logic [rail_seq_pkg::CNT_W-1:0] term;
   logic done;
   logic chk_good;
   logic in_wait;

   assign term = (state_ff == rail_seq_pkg::ST_EN_WAIT) ?
                 rail_seq_pkg::CNT_W'(EN_CYC - 1) :
                 (state_ff == rail_seq_pkg::ST_RST_WAIT) ?
                 rail_seq_pkg::CNT_W'(RST_CYC - 1) :
                 rail_seq_pkg::CNT_W'(MON_CYC - 1);
   assign done = (cnt_ff == term);
   assign in_wait = (state_ff != rail_seq_pkg::ST_OFF) && (state_ff != rail_seq_pkg::ST_ON) &&
                    (state_ff != rail_seq_pkg::ST_FAULT);
   assign chk_good = (state_ff == rail_seq_pkg::ST_CORE) ? good_flt[0] :
                     (state_ff == rail_seq_pkg::ST_MID) ? good_flt[1] : good_flt[2];

   always_comb
   begin
      nxt_state = state_ff;
      case (state_ff)
         rail_seq_pkg::ST_OFF:
            if (req_rise)
               nxt_state = rail_seq_pkg::ST_EN_WAIT;
         rail_seq_pkg::ST_EN_WAIT:
            if (done)
               nxt_state = rail_seq_pkg::ST_CORE;
         rail_seq_pkg::ST_CORE, rail_seq_pkg::ST_MID, rail_seq_pkg::ST_IO:
            if (done && !chk_good)
               nxt_state = rail_seq_pkg::ST_FAULT;
            else if (done && state_ff == rail_seq_pkg::ST_CORE)
               nxt_state = rail_seq_pkg::ST_MID;
            else if (done && state_ff == rail_seq_pkg::ST_MID)
               nxt_state = rail_seq_pkg::ST_IO;
            else if (done)
               nxt_state = rail_seq_pkg::ST_RST_WAIT;
         rail_seq_pkg::ST_RST_WAIT:
            if (done)
               nxt_state = rail_seq_pkg::ST_ON;
         rail_seq_pkg::ST_ON:
            nxt_state = rail_seq_pkg::ST_ON;
         rail_seq_pkg::ST_FAULT:
            nxt_state = rail_seq_pkg::ST_FAULT;
         default:
            nxt_state = rail_seq_pkg::ST_OFF;
      endcase
      // Request low restarts the whole sequence; the rise itself is seen before req_ff
      if (!req_ff && !req_rise)
         nxt_state = rail_seq_pkg::ST_OFF;
   end

   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         state_ff <= rail_seq_pkg::ST_OFF;
         cnt_ff <= '0;
      end
      else
      begin
         state_ff <= nxt_state;
         cnt_ff <= (nxt_state != state_ff || !in_wait) ? '0 : cnt_ff + 1'b1;
      end
   end

   // ****************************************
   // Outputs
   // ****************************************
   logic core_en_ff;
   logic mid_en_ff;
   logic io_en_ff;
   logic rst_n_ff;
   logic fault_ff;
   always_ff @(posedge core_clk)
   begin
      if (!rst_n)
      begin
         core_en_ff <= 1'b0;
         mid_en_ff <= 1'b0;
         io_en_ff <= 1'b0;
         rst_n_ff <= 1'b0;
         fault_ff <= 1'b0;
      end
      else
      begin
         // Enables already on stay on after a fault; later enables and reset release are withheld
         core_en_ff <= (nxt_state != rail_seq_pkg::ST_OFF) &&
                       (nxt_state != rail_seq_pkg::ST_EN_WAIT);
         mid_en_ff <= (nxt_state == rail_seq_pkg::ST_MID) || (nxt_state == rail_seq_pkg::ST_IO) ||
                      (nxt_state == rail_seq_pkg::ST_RST_WAIT) ||
                      (nxt_state == rail_seq_pkg::ST_ON) ||
                      (mid_en_ff && nxt_state == rail_seq_pkg::ST_FAULT);
         io_en_ff <= (nxt_state == rail_seq_pkg::ST_IO) ||
                     (nxt_state == rail_seq_pkg::ST_RST_WAIT) ||
                     (nxt_state == rail_seq_pkg::ST_ON) ||
                     (io_en_ff && nxt_state == rail_seq_pkg::ST_FAULT);
         rst_n_ff <= (nxt_state == rail_seq_pkg::ST_ON);
         fault_ff <= (nxt_state == rail_seq_pkg::ST_FAULT);
      end
   end
   assign core_rail_enable = core_en_ff;
   assign mid_rail_enable = mid_en_ff;
   assign io_rail_enable = io_en_ff;
   assign system_reset_n = rst_n_ff;
   assign seq_fault = fault_ff;

   // ****************************************
   // Checks
   // ****************************************
   a_core_en_delay: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(state_ff == rail_seq_pkg::ST_EN_WAIT) && req_ff |->
      !core_rail_enable [*8])
      else $error("core enable rose too early");
   a_core_mon_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(core_rail_enable) |-> !mid_rail_enable [*8])
      else $error("mid enable before core wait");
   a_mid_mon_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(mid_rail_enable) |-> !io_rail_enable [*8])
      else $error("io enable before mid wait");
   a_io_mon_wait: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(io_rail_enable) |-> !system_reset_n [*8])
      else $error("reset released before io wait");
   a_reset_release: assert property (@(posedge core_clk) disable iff (!rst_n)
      $rose(system_reset_n) |-> io_rail_enable && mid_rail_enable && core_rail_enable)
      else $error("reset released without all rails");
   a_fault_holds: assert property (@(posedge core_clk) disable iff (!rst_n)
      seq_fault |-> !system_reset_n)
      else $error("reset released during fault");
   a_rail_order: assert property (@(posedge core_clk) disable iff (!rst_n)
      (io_rail_enable |-> mid_rail_enable) and (mid_rail_enable |-> core_rail_enable))
      else $error("rail enables out of order");
   a_fault_on_bad: assert property (@(posedge core_clk) disable iff (!rst_n)
      (state_ff == rail_seq_pkg::ST_CORE) && done && !good_flt[0] && req_ff
      |=> seq_fault)
      else $error("failed core test not caught");
   a_glitch_ignored: assert property (@(posedge core_clk) disable iff (!rst_n)
      g_flt[1].good_ff && (g_flt[1].low_cnt_ff < rail_seq_pkg::FLT_W'(GLITCH_CYC))
      |=> g_flt[1].good_ff)
      else $error("monitor dropped on short dip");
endmodule : power_up_rail_sequencer

// [bench/rail_model.sv]
// Regulator and supply monitor model for the rail sequencer bench
`timescale 1ns/1ps
module rail_model
#(
   parameter int RAMP = 2000
)
(
   // Clock
   input wire logic core_clk,
   // Enables from the sequencer
   input wire logic core_rail_enable,
   input wire logic mid_rail_enable,
   input wire logic io_rail_enable,
   // Bench controls
   input wire logic early_on,
   input wire logic hold_core_low,
   input wire logic dip_mid,
   // Monitor outputs
   output logic core_rail_good,
   output logic mid_rail_good,
   output logic io_rail_good
);
   // ****************************************
   // Rail ramp
   // ****************************************
   logic [2:0] en;
   logic [15:0] ramp_ff [3];
   // Supplies may be brought up before their enables
   assign en = {io_rail_enable, mid_rail_enable, core_rail_enable} | {3{early_on}};
   always_ff @(posedge core_clk)
   begin
      for (int i = 0; i < 3; i++)
      begin
         ramp_ff[i] <= !en[i] ? 16'h0 : (ramp_ff[i] == 16'(RAMP)) ? ramp_ff[i] : ramp_ff[i] + 16'h1;
      end
   end
   // A slow ramp, so a monitor tested early would see the rail still low
   assign core_rail_good = (ramp_ff[0] == 16'(RAMP)) && !hold_core_low;
   assign mid_rail_good = (ramp_ff[1] == 16'(RAMP)) && !dip_mid;
   assign io_rail_good = (ramp_ff[2] == 16'(RAMP));
endmodule : rail_model

// [bench/tb_top.sv]
// Self-checking bench for the power-up rail sequencer
`timescale 1ns/1ps
module tb_top;
   // ****************************************
   // Setup
   // ****************************************
   // Design runs at a scaled rate so the whole run stays near 90 thousand cycles
   localparam int SIM_HZ = 1000000;
   localparam int LIMIT = 98000;
   localparam int EN = rail_seq_pkg::EN_DLY_MS * (SIM_HZ / 1000);
   localparam int MON = rail_seq_pkg::MON_MS * (SIM_HZ / 1000);
   localparam int RST = rail_seq_pkg::RST_DLY_MS * (SIM_HZ / 1000);
   localparam int FLT = rail_seq_pkg::GLITCH_MIN_US * (SIM_HZ / 1000000);
   logic core_clk = 1'b0;
   logic rst_n = 1'b0;
   logic system_on_request = 1'b0;
   logic early_on = 1'b0;
   logic hold_core_low = 1'b0;
   logic dip_mid = 1'b0;
   logic core_rail_good, mid_rail_good, io_rail_good;
   logic core_rail_enable, mid_rail_enable, io_rail_enable, system_reset_n, seq_fault;
   int err_total = 0;
   int checks = 0;
   int cyc = 0;
   power_up_rail_sequencer #(.CLK_HZ(SIM_HZ)) i_power_up_rail_sequencer (.core_clk(core_clk),
      .rst_n(rst_n),
      .system_on_request(system_on_request), .core_rail_good(core_rail_good),
      .mid_rail_good(mid_rail_good), .io_rail_good(io_rail_good),
      .core_rail_enable(core_rail_enable), .mid_rail_enable(mid_rail_enable),
      .io_rail_enable(io_rail_enable), .system_reset_n(system_reset_n), .seq_fault(seq_fault));
   rail_model i_rail_model (.core_clk(core_clk), .core_rail_enable(core_rail_enable),
      .mid_rail_enable(mid_rail_enable), .io_rail_enable(io_rail_enable), .early_on(early_on),
      .hold_core_low(hold_core_low), .dip_mid(dip_mid), .core_rail_good(core_rail_good),
      .mid_rail_good(mid_rail_good), .io_rail_good(io_rail_good));
   always #20 core_clk = ~core_clk;
   always @(posedge core_clk)
   begin
      cyc++;
      if (cyc == LIMIT)
      begin
         err_total++;
         conclude();
      end
   end
   // ****************************************
   // Helpers
   // ****************************************
   task automatic conclude;
      if (err_total == 0 && checks > 0)
         $display("TEST PASSED");
      else
         $display("TEST FAILED");
      $finish;
   endtask : conclude
   task automatic chk_bit(input string what, input logic exp, input logic got);
      checks++;
      if (got !== exp)
      begin
         err_total++;
         $display("MISMATCH %s expected %b seen %b", what, exp, got);
      end
   endtask : chk_bit
   task automatic chk_span(input string what, input int lo, input int hi, input int got);
      checks++;
      if (got < lo || got > hi)
      begin
         err_total++;
         $display("MISMATCH %s expected %0d..%0d seen %0d", what, lo, hi, got);
      end
   endtask : chk_span
   function automatic logic pick(input int k);
      case (k)
         0: return core_rail_enable;
         1: return mid_rail_enable;
         2: return io_rail_enable;
         default: return system_reset_n;
      endcase
   endfunction : pick
   // Sample on the falling edge so registered outputs have settled
   task automatic wait_high(input int k);
      int c;
      c = 0;
      while (pick(k) !== 1'b1 && c < LIMIT)
      begin
         @(negedge core_clk);
         c++;
      end
   endtask : wait_high
   task automatic idle(input int c);
      repeat (c) @(negedge core_clk);
   endtask : idle
   task automatic set_req(input logic v);
      @(posedge core_clk);
      system_on_request <= v;
   endtask : set_req
   // ****************************************
   // Scenarios
   // ****************************************
   task automatic t_full;
      int t;
      @(posedge core_clk);
      early_on <= 1'b1;
      idle(2100);
      set_req(1'b1);
      t = cyc;
      wait_high(0);
      chk_span("core delay", EN, EN + 6, cyc - t);
      chk_bit("mid early", 1'b0, mid_rail_enable);
      t = cyc;
      wait_high(1);
      chk_span("mid delay", MON - 1, MON + 1, cyc - t);
      chk_bit("io early", 1'b0, io_rail_enable);
      t = cyc;
      wait_high(2);
      chk_span("io delay", MON - 1, MON + 1, cyc - t);
      chk_bit("reset early", 1'b0, system_reset_n);
      t = cyc;
      idle(1000);
      @(posedge core_clk);
      dip_mid <= 1'b1;
      repeat (FLT / 2) @(posedge core_clk);
      dip_mid <= 1'b0;
      wait_high(3);
      chk_span("reset delay", MON + RST - 2, MON + RST + 2, cyc - t);
      chk_bit("fault after dip", 1'b0, seq_fault);
      chk_bit("mid after dip", 1'b1, mid_rail_enable);
      set_req(1'b0);
      idle(8);
      chk_bit("core off", 1'b0, core_rail_enable);
      chk_bit("reset off", 1'b0, system_reset_n);
   endtask : t_full
   task automatic t_fail;
      int t;
      @(posedge core_clk);
      early_on <= 1'b0;
      hold_core_low <= 1'b1;
      set_req(1'b1);
      wait_high(0);
      idle(MON + FLT + 20);
      chk_bit("fault set", 1'b1, seq_fault);
      chk_bit("mid held off", 1'b0, mid_rail_enable);
      chk_bit("reset held", 1'b0, system_reset_n);
      @(posedge core_clk);
      hold_core_low <= 1'b0;
      idle(5000);
      chk_bit("fault stays", 1'b1, seq_fault);
      chk_bit("no late mid", 1'b0, mid_rail_enable);
      set_req(1'b0);
      idle(8);
      chk_bit("fault clear", 1'b0, seq_fault);
      set_req(1'b1);
      t = cyc;
      wait_high(0);
      chk_span("restart delay", EN, EN + 6, cyc - t);
      set_req(1'b0);
      idle(8);
   endtask : t_fail
   initial
   begin
      repeat (10) @(posedge core_clk);
      rst_n <= 1'b1;
      idle(5);
      t_full();
      t_fail();
      conclude();
   end
endmodule : tb_top
